// ==== design/ces_pkg.sv ====
// Constants and carrier types for the CPU exception sequencer.
// Assumes a 24-bit byte address space and a 16-bit word memory bus.
package ces_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_CCR    = 8'h01;
   localparam logic [7:0] OFS_EXR    = 8'h02;
   localparam logic [7:0] OFS_MSTPA  = 8'h03;
   localparam logic [7:0] OFS_MSTPB  = 8'h04;
   localparam logic [7:0] OFS_MSTPC  = 8'h05;
   localparam logic [7:0] OFS_STATUS = 8'h06;
   // Field positions
   localparam int CCR_I_POS  = 7;
   localparam int CCR_UI_POS = 6;
   localparam int EXR_T_POS  = 7;
   // Reset values
   localparam logic [7:0] CCR_RST   = 8'h80;
   localparam logic [7:0] EXR_RST   = 8'h07;
   localparam logic [7:0] MSTPA_RST = 8'h3F;
   localparam logic [7:0] MSTPB_RST = 8'hFF;
   localparam logic [7:0] MSTPC_RST = 8'hFF;
   // Control mode codes
   localparam logic [1:0] MODE_0 = 2'h0;
   localparam logic [1:0] MODE_2 = 2'h2;
   // Vector numbers and NMI level
   localparam logic [6:0] VEC_RESET  = 7'h00;
   localparam logic [6:0] VEC_TRACE  = 7'h05;
   localparam logic [6:0] VEC_DIRECT = 7'h06;
   localparam logic [6:0] VEC_NMI    = 7'h07;
   localparam logic [6:0] VEC_TRAP0  = 7'h08;
   localparam logic [2:0] NMI_LEVEL  = 3'h7;
   // Memory request carried to the bus
   typedef struct packed {
      logic        req;
      logic        we;
      logic [23:0] addr;
      logic [15:0] wdata;
   } ces_mem_t;
   // Interrupt request from the interrupt controller
   typedef struct packed {
      logic       nmi;
      logic       irq;
      logic [6:0] vec;
      logic [2:0] lvl;
   } ces_irq_t;
   // Sequencer states
   typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_VEC0, ST_VEC1} ces_state_t;
endpackage : ces_pkg

// ==== design/ces_seq.sv ====
// Exception sequencer: vector selection, stacking, vector fetch, flag update.
// Assumes instruction sequencer, interrupt controller and memory bus run on CLK_I;
// NRST_I is the chip init pin and acts as asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Each source owns vector 0..127
// - Vector address uses lower 16 address bits
// - Reset beats every other source
// - Low init pin halts and holds reset
// - Watchdog overflow resets like the pin
// - Control mode 0 after reset
// - Reset clears trace, sets mask flags
// - Reset vector loads PC, fetch starts
// - All interrupts blocked until first instruction
// - Module stop registers load 3F, FF, FF
// - Trace only in control mode 2
// - Trace after every instruction, ignoring masks
// - Trace sets I, clears trace flag
// - No trace right after return instruction
// - Interrupts accepted inside trace handler
// - Eight mask levels except nonmaskable
// - Interrupt stacks PC, COND_CODE_REG, EXTENDED_CTRL_REG (mode 2 only); updates flags
// - Trap instruction handled like an interrupt
// - Trap number 0..3 selects vectors 8..11
// - Trap sets I; clears trace in mode 2
// - Word accesses force address bit zero
// - Order: reset, trace, direct, interrupt, trap
// - No interrupt after flag insns or reset
// - Mode codes 00 and 10 only
module ces_seq (
   input  wire logic             CLK_I,
   input  wire logic             NRST_I,
   input  wire logic             WDT_OVF_I,
   input  wire logic [7:0]       ADDR_I,
   input  wire logic [7:0]       WDATA_I,
   input  wire logic             WR_I,
   input  wire logic             RD_I,
   output logic      [7:0]       RDATA_O,
   input  wire logic             INSN_DONE_I,
   input  wire logic             INSN_RTE_I,
   input  wire logic             INSN_FLAG_I,
   input  wire logic             TRAP_I,
   input  wire logic [1:0]       TRAP_NUM_I,
   input  wire logic             DIRECT_I,
   input  wire ces_pkg::ces_irq_t IRQ_I,
   input  wire logic [23:0]      PC_I,
   input  wire logic [23:0]      SP_I,
   input  wire logic             CCR_WR_I,
   input  wire logic [7:0]       CCR_I,
   input  wire logic             EXR_WR_I,
   input  wire logic [7:0]       EXR_I,
   output ces_pkg::ces_mem_t     MEM_O,
   input  wire logic             MEM_ACK_I,
   input  wire logic [15:0]      MEM_RDATA_I,
   output logic                  PC_LOAD_O,
   output logic      [23:0]      PC_O,
   output logic                  SP_LOAD_O,
   output logic      [23:0]      SP_O,
   output logic                  BUSY_O,
   output logic                  INT_ACK_O,
   output logic      [7:0]       CCR_O,
   output logic      [7:0]       EXR_O,
   output logic      [1:0]       MODE_O,
   output logic      [7:0]       MSTPA_O,
   output logic      [7:0]       MSTPB_O,
   output logic      [7:0]       MSTPC_O
);
   import ces_pkg::*;

   // Vector table word address: low 16 bits only, four bytes per entry
   function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic second);
      vec_addr = {8'h00, 7'h00, vec, second, 1'b0};
   endfunction : vec_addr

   // Word access address with bit zero forced low
   function automatic logic [23:0] word_addr(input logic [23:0] a);
      word_addr = {a[23:1], 1'b0};
   endfunction : word_addr

   ces_state_t  state_reg, state_next;
   ces_mem_t    mem_reg, mem_next;
   logic [6:0]  vec_reg, vec_next;
   logic [1:0]  push_cnt_reg, push_cnt_next;
   logic [23:0] sp_reg, sp_next;
   logic [23:0] pc_reg, pc_next;
   logic [23:0] stk_pc_reg, stk_pc_next;
   logic [7:0]  stk_ccr_reg, stk_ccr_next;
   logic [7:0]  stk_exr_reg, stk_exr_next;
   logic [7:0]  hi_reg, hi_next;
   logic [7:0]  ccr_reg, ccr_next;
   logic [7:0]  exr_reg, exr_next;
   logic        blk_reg, blk_next;
   logic        trap_pend_reg, trap_pend_next;
   logic [1:0]  trap_num_reg, trap_num_next;
   logic        pc_ld_reg, pc_ld_next;
   logic        sp_ld_reg, sp_ld_next;
   logic        ack_reg, ack_next;
   logic [1:0]  mode_reg, mode_next;
   logic [7:0]  mstpa_reg, mstpa_next;
   logic [7:0]  mstpb_reg, mstpb_next;
   logic [7:0]  mstpc_reg, mstpc_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        mode2;
   logic        trace_ok;
   logic        irq_ok;
   logic        decide;

   assign mode2 = (mode_reg == MODE_2);
   // Trace needs mode 2 and never follows a return instruction
   assign trace_ok = mode2 && exr_reg[EXR_T_POS] && !INSN_RTE_I;
   // Masks checked against COND_CODE_REG I in mode 0, against the level mask in mode 2;
   // blocked after reset and after flag instructions
   assign irq_ok = !blk_reg && !INSN_FLAG_I && (IRQ_I.nmi || (IRQ_I.irq &&
                   (mode2 ? (IRQ_I.lvl > exr_reg[2:0]) : !ccr_reg[CCR_I_POS])));
   assign decide = (state_reg == ST_RUN) && (INSN_DONE_I || trap_pend_reg);

   // Sequencer next state
   always_comb begin
      state_next     = state_reg;
      mem_next       = mem_reg;
      vec_next       = vec_reg;
      push_cnt_next  = push_cnt_reg;
      sp_next        = sp_reg;
      pc_next        = pc_reg;
      stk_pc_next    = stk_pc_reg;
      stk_ccr_next   = stk_ccr_reg;
      stk_exr_next   = stk_exr_reg;
      hi_next        = hi_reg;
      ccr_next       = ccr_reg;
      exr_next       = exr_reg;
      blk_next       = blk_reg;
      trap_pend_next = trap_pend_reg;
      trap_num_next  = trap_num_reg;
      pc_ld_next     = 1'b0;
      sp_ld_next     = 1'b0;
      ack_next       = 1'b0;
      // Flag writes from the instruction sequencer, e.g. on return
      if (CCR_WR_I) begin
         ccr_next = CCR_I;
      end
      if (EXR_WR_I) begin
         exr_next = EXR_I;
      end
      // A trap request is remembered until a decision point takes it
      if (INSN_DONE_I && TRAP_I) begin
         trap_pend_next = 1'b1;
         trap_num_next  = TRAP_NUM_I;
      end
      if (decide) begin
         stk_pc_next  = PC_I;
         stk_ccr_next = ccr_reg;
         stk_exr_next = exr_reg;
         sp_next      = SP_I;
         state_next   = ST_PUSH;
         push_cnt_next = 2'h0;
         if (INSN_DONE_I) begin
            blk_next = 1'b0;
         end
         // Fixed order of service among simultaneous sources
         if (INSN_DONE_I && trace_ok) begin
            vec_next = VEC_TRACE;
            ccr_next[CCR_I_POS] = 1'b1;
            exr_next[EXR_T_POS] = 1'b0;
         end else if (INSN_DONE_I && DIRECT_I) begin
            vec_next = VEC_DIRECT;
            ccr_next[CCR_I_POS] = 1'b1;
            exr_next[EXR_T_POS] = 1'b0;
         end else if (INSN_DONE_I && irq_ok) begin
            vec_next = IRQ_I.nmi ? VEC_NMI : IRQ_I.vec;
            ack_next = 1'b1;
            exr_next[EXR_T_POS] = 1'b0;
            if (mode2) begin
               exr_next[2:0] = IRQ_I.nmi ? NMI_LEVEL : IRQ_I.lvl;
            end else begin
               ccr_next[CCR_I_POS] = 1'b1;
            end
         end else if (trap_pend_reg || (INSN_DONE_I && TRAP_I)) begin
            // A new trap arriving while an older one is served stays pending
            trap_pend_next = trap_pend_reg && INSN_DONE_I && TRAP_I;
            vec_next = VEC_TRAP0 + {5'h00, (trap_pend_reg ? trap_num_reg : TRAP_NUM_I)};
            ccr_next[CCR_I_POS] = 1'b1;
            if (mode2) begin
               exr_next[EXR_T_POS] = 1'b0;
            end
         end else begin
            state_next = ST_RUN;
         end
      end
      case (state_reg)
         ST_RUN: begin
         end
         // Stacking: PC low, then COND_CODE_REG with PC high, then EXTENDED_CTRL_REG in mode 2
         ST_PUSH: begin
            if (!mem_reg.req) begin
               mem_next.req  = 1'b1;
               mem_next.we   = 1'b1;
               mem_next.addr = word_addr(sp_reg - 24'h000002);
               case (push_cnt_reg)
                  2'h0:    mem_next.wdata = stk_pc_reg[15:0];
                  2'h1:    mem_next.wdata = {stk_ccr_reg, stk_pc_reg[23:16]};
                  default: mem_next.wdata = {stk_exr_reg, 8'h00};
               endcase
            end else if (MEM_ACK_I) begin
               mem_next.req  = 1'b0;
               sp_next       = sp_reg - 24'h000002;
               push_cnt_next = push_cnt_reg + 2'h1;
               if (push_cnt_reg == 2'h2 || (push_cnt_reg == 2'h1 && !mode2)) begin
                  sp_ld_next = 1'b1;
                  state_next = ST_VEC0;
               end
            end
         end
         // Vector fetch: upper word then lower word of the start address
         ST_VEC0, ST_VEC1: begin
            if (!mem_reg.req) begin
               mem_next.req  = 1'b1;
               mem_next.we   = 1'b0;
               mem_next.addr = vec_addr(vec_reg, state_reg == ST_VEC1);
               mem_next.wdata = 16'h0000;
            end else if (MEM_ACK_I) begin
               mem_next.req = 1'b0;
               if (state_reg == ST_VEC0) begin
                  hi_next    = MEM_RDATA_I[7:0];
                  state_next = ST_VEC1;
               end else begin
                  pc_next    = {hi_reg, MEM_RDATA_I};
                  pc_ld_next = 1'b1;
                  state_next = ST_RUN;
               end
            end
         end
         default: state_next = ST_RUN;
      endcase
      // Watchdog overflow repeats the pin reset, overriding everything else
      if (WDT_OVF_I) begin
         state_next     = ST_VEC0;
         mem_next       = '0;
         vec_next       = VEC_RESET;
         ccr_next       = CCR_RST;
         exr_next       = EXR_RST;
         blk_next       = 1'b1;
         trap_pend_next = 1'b0;
         pc_ld_next     = 1'b0;
         sp_ld_next     = 1'b0;
         ack_next       = 1'b0;
      end
   end

   // Sequencer registers; a low init pin holds all of them in reset
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_reg     <= ST_VEC0;
         mem_reg       <= '0;
         vec_reg       <= VEC_RESET;
         push_cnt_reg  <= 2'h0;
         sp_reg        <= 24'h000000;
         pc_reg        <= 24'h000000;
         stk_pc_reg    <= 24'h000000;
         stk_ccr_reg   <= 8'h00;
         stk_exr_reg   <= 8'h00;
         hi_reg        <= 8'h00;
         ccr_reg       <= CCR_RST;
         exr_reg       <= EXR_RST;
         blk_reg       <= 1'b1;
         trap_pend_reg <= 1'b0;
         trap_num_reg  <= 2'h0;
         pc_ld_reg     <= 1'b0;
         sp_ld_reg     <= 1'b0;
         ack_reg       <= 1'b0;
      end else begin
         state_reg     <= state_next;
         mem_reg       <= mem_next;
         vec_reg       <= vec_next;
         push_cnt_reg  <= push_cnt_next;
         sp_reg        <= sp_next;
         pc_reg        <= pc_next;
         stk_pc_reg    <= stk_pc_next;
         stk_ccr_reg   <= stk_ccr_next;
         stk_exr_reg   <= stk_exr_next;
         hi_reg        <= hi_next;
         ccr_reg       <= ccr_next;
         exr_reg       <= exr_next;
         blk_reg       <= blk_next;
         trap_pend_reg <= trap_pend_next;
         trap_num_reg  <= trap_num_next;
         pc_ld_reg     <= pc_ld_next;
         sp_ld_reg     <= sp_ld_next;
         ack_reg       <= ack_next;
      end
   end

   // Register port next values; prohibited mode codes are ignored
   always_comb begin
      mode_next  = mode_reg;
      mstpa_next = mstpa_reg;
      mstpb_next = mstpb_reg;
      mstpc_next = mstpc_reg;
      rdata_next = 8'h00;
      if (WR_I) begin
         case (ADDR_I)
            OFS_MODE: begin
               if (WDATA_I[1:0] == MODE_0 || WDATA_I[1:0] == MODE_2) begin
                  mode_next = WDATA_I[1:0];
               end
            end
            OFS_MSTPA: mstpa_next = WDATA_I;
            OFS_MSTPB: mstpb_next = WDATA_I;
            OFS_MSTPC: mstpc_next = WDATA_I;
            default: begin
            end
         endcase
      end
      if (RD_I) begin
         case (ADDR_I)
            OFS_MODE:   rdata_next = {6'h00, mode_reg};
            OFS_CCR:    rdata_next = ccr_reg;
            OFS_EXR:    rdata_next = exr_reg;
            OFS_MSTPA:  rdata_next = mstpa_reg;
            OFS_MSTPB:  rdata_next = mstpb_reg;
            OFS_MSTPC:  rdata_next = mstpc_reg;
            OFS_STATUS: rdata_next = {blk_reg, vec_reg};
            default:    rdata_next = 8'h00;
         endcase
      end
      // Watchdog reset restores mode and module stop state as the pin does
      if (WDT_OVF_I) begin
         mode_next  = MODE_0;
         mstpa_next = MSTPA_RST;
         mstpb_next = MSTPB_RST;
         mstpc_next = MSTPC_RST;
      end
   end

   // Register port flops
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mode_reg  <= MODE_0;
         mstpa_reg <= MSTPA_RST;
         mstpb_reg <= MSTPB_RST;
         mstpc_reg <= MSTPC_RST;
         rdata_reg <= 8'h00;
      end else begin
         mode_reg  <= mode_next;
         mstpa_reg <= mstpa_next;
         mstpb_reg <= mstpb_next;
         mstpc_reg <= mstpc_next;
         rdata_reg <= rdata_next;
      end
   end

   // Outputs, all from flops except the busy level
   assign RDATA_O   = rdata_reg;
   assign MEM_O     = mem_reg;
   assign PC_LOAD_O = pc_ld_reg;
   assign PC_O      = pc_reg;
   assign SP_LOAD_O = sp_ld_reg;
   assign SP_O      = sp_reg;
   assign BUSY_O    = (state_reg != ST_RUN);
   assign INT_ACK_O = ack_reg;
   assign CCR_O     = ccr_reg;
   assign EXR_O     = exr_reg;
   assign MODE_O    = mode_reg;
   assign MSTPA_O   = mstpa_reg;
   assign MSTPB_O   = mstpb_reg;
   assign MSTPC_O   = mstpc_reg;

endmodule : ces_seq
`default_nettype wire

// ==== bench/ces_mem_model.sv ====
// Memory bus partner: answers stacking writes and vector-table reads.
// Assumes the sequencer holds its request until it has seen the acknowledge.
`timescale 1ns/10ps
`default_nettype none
module ces_mem_model (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic              slow_i,
   input  wire ces_pkg::ces_mem_t mem_i,
   output logic                   ack_o,
   output logic      [15:0]       rdata_o
);
   import ces_pkg::*;
   logic [1:0] wait_reg;
   // Slow mode stalls each access three extra cycles so the request must stand
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_o    <= 1'b0;
         wait_reg <= 2'h0;
      end else if (mem_i.req && !ack_o && (!slow_i || wait_reg == 2'h3)) begin
         ack_o    <= 1'b1;
         wait_reg <= 2'h0;
      end else begin
         ack_o    <= 1'b0;
         wait_reg <= mem_i.req ? wait_reg + 2'h1 : 2'h0;
      end
   end
   // Table word depends on the low 16 address bits only; off the ack it is inverted
   assign rdata_o = ack_o ? (mem_i.addr[15:0] ^ 16'h5A5A) : ~(mem_i.addr[15:0] ^ 16'h5A5A);
endmodule : ces_mem_model
`default_nettype wire

// ==== bench/ces_chk_chk.sv ====
// Port checker for the exception sequencer.
// Assumes it is bound into ces_seq and sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none
module ces_chk (
   input wire logic              CLK_I,
   input wire logic              NRST_I,
   input wire logic              WDT_OVF_I,
   input wire logic              INSN_DONE_I,
   input wire logic              INSN_RTE_I,
   input wire logic              TRAP_I,
   input wire logic              DIRECT_I,
   input wire ces_pkg::ces_irq_t IRQ_I,
   input wire logic      [23:0]  PC_I,
   input wire logic      [23:0]  SP_I,
   input wire ces_pkg::ces_mem_t MEM_O,
   input wire logic              MEM_ACK_I,
   input wire logic              PC_LOAD_O,
   input wire logic              SP_LOAD_O,
   input wire logic      [23:0]  SP_O,
   input wire logic              BUSY_O,
   input wire logic              INT_ACK_O,
   input wire logic      [7:0]   CCR_O,
   input wire logic      [7:0]   EXR_O,
   input wire logic      [1:0]   MODE_O,
   input wire logic      [7:0]   MSTPA_O,
   input wire logic      [7:0]   MSTPB_O,
   input wire logic      [7:0]   MSTPC_O
);
   import ces_pkg::*;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   // Instruction end with no other source competing
   logic quiet_done;
   assign quiet_done = INSN_DONE_I && !BUSY_O && !TRAP_I && !DIRECT_I && !IRQ_I.nmi && !IRQ_I.irq && !WDT_OVF_I;
   AST_RST_FLAGS:
      assert property (!$past(NRST_I) |-> CCR_O == CCR_RST && EXR_O == EXR_RST && MODE_O == MODE_0)
      else $error("flags wrong after reset");
   AST_RST_STOP:
      assert property (!$past(NRST_I) |-> MSTPA_O == MSTPA_RST && MSTPB_O == MSTPB_RST && MSTPC_O == MSTPC_RST)
      else $error("module stop values wrong after reset");
   AST_RST_FETCH:
      assert property (!$past(NRST_I) |=> MEM_O.req && !MEM_O.we && MEM_O.addr == 24'h000000)
      else $error("reset vector fetch missing");
   AST_WORD_ALIGN:
      assert property (MEM_O.req |-> !MEM_O.addr[0])
      else $error("odd word address");
   AST_REQ_HOLD:
      assert property (MEM_O.req && !MEM_ACK_I && !WDT_OVF_I |=> $stable(MEM_O))
      else $error("request changed before ack");
   AST_FIRST_PUSH:
      assert property (INT_ACK_O |=> MEM_O.req && MEM_O.we && MEM_O.addr == SP_I - 24'h2
                       && MEM_O.wdata == PC_I[15:0])
      else $error("first push wrong");
   AST_ACK_FLAGS:
      assert property (INT_ACK_O |-> !EXR_O[EXR_T_POS] && (MODE_O == MODE_2 || CCR_O[CCR_I_POS]))
      else $error("flags not updated on interrupt");
   AST_SP_LOAD:
      assert property (SP_LOAD_O |-> SP_O == SP_I - (MODE_O == MODE_2 ? 24'h6 : 24'h4))
      else $error("stack pointer after stacking wrong");
   AST_NO_TRACE:
      assert property (quiet_done && (MODE_O == MODE_0 || INSN_RTE_I) |=> !BUSY_O)
      else $error("trace taken where forbidden");
   AST_TRACE_TAKE:
      assert property (quiet_done && !INSN_RTE_I && MODE_O == MODE_2 && EXR_O[EXR_T_POS]
                       |=> BUSY_O && CCR_O[CCR_I_POS] && !EXR_O[EXR_T_POS])
      else $error("trace not taken");
   AST_DONE_BOUND:
      assert property ($rose(BUSY_O) |-> ##[2:80] PC_LOAD_O)
      else $error("handling did not finish");
   AST_BUSY_END:
      assert property (PC_LOAD_O |-> !BUSY_O && $past(BUSY_O))
      else $error("busy not released after load");
   // Main scenarios seen at least once
   cover property (INT_ACK_O);
   cover property (SP_LOAD_O && MODE_O == MODE_2);
   cover property (quiet_done && MODE_O == MODE_2 && EXR_O[EXR_T_POS]);
endmodule : ces_chk
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the exception sequencer with a memory partner.
// Assumes ces_pkg, ces_seq, ces_mem_model and ces_chk are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ces_pkg::*;
   logic        clk, nrst, wdt, wr, rd, rd_q, slow, done, return_from_exception, flg, trp, dir, ccr_wr, exr_wr, ack, pc_load, busy;
   logic [7:0]  ad, wd, cond_code_reg, extended_ctrl_reg, rdata, f;
   logic [1:0]  tnum;
   logic [6:0]  v;
   logic [23:0] pc, sp, pc_o;
   logic [15:0] mrd;
   ces_irq_t    irq;
   ces_mem_t    mem;
   int          err_count, compares, npc;
   logic [23:0] exp_pc[$];
   logic [7:0]  exp_rd[$];
   always #50 clk = ~clk;
   ces_seq uut (.CLK_I(clk), .NRST_I(nrst), .WDT_OVF_I(wdt), .ADDR_I(ad), .WDATA_I(wd), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .INSN_DONE_I(done), .INSN_RTE_I(return_from_exception), .INSN_FLAG_I(flg), .TRAP_I(trp),
      .TRAP_NUM_I(tnum), .DIRECT_I(dir), .IRQ_I(irq), .PC_I(pc), .SP_I(sp), .CCR_WR_I(ccr_wr), .CCR_I(cond_code_reg),
      .EXR_WR_I(exr_wr), .EXR_I(extended_ctrl_reg), .MEM_O(mem), .MEM_ACK_I(ack), .MEM_RDATA_I(mrd), .PC_LOAD_O(pc_load),
      .PC_O(pc_o), .SP_LOAD_O(), .SP_O(), .BUSY_O(busy), .INT_ACK_O(), .CCR_O(), .EXR_O(), .MODE_O(),
      .MSTPA_O(), .MSTPB_O(), .MSTPC_O());
   ces_mem_model mem_m (.clk_i(clk), .nrst_i(nrst), .slow_i(slow), .mem_i(mem), .ack_o(ack), .rdata_o(mrd));
   // Handler start address as the partner's table holds it
   function automatic logic [23:0] vpc(input logic [6:0] n);
      logic [15:0] hi, lo;
      hi = {7'h00, n, 2'h0} ^ 16'h5A5A;
      lo = {7'h00, n, 2'h2} ^ 16'h5A5A;
      return {hi[7:0], lo};
   endfunction : vpc
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
      compares++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         err_count++;
      end
   endtask : chk
   // Results are matched against the oldest note as they appear
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q) chk("rdata", 24'(exp_rd.pop_front()), 24'(rdata));
      if (pc_load === 1'b1) begin
         npc <= npc + 1;
         chk("pc", exp_pc.pop_front(), pc_o);
      end
   end
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      @(posedge clk);
      ad <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : rreg
   task automatic setf(input logic [7:0] c, input logic [7:0] e);
      @(posedge clk);
      cond_code_reg <= c;
      extended_ctrl_reg <= e;
      {ccr_wr, exr_wr} <= 2'h3;
      @(posedge clk);
      {ccr_wr, exr_wr} <= 2'h0;
   endtask : setf
   // One completed instruction; stack pointer kept even
   task automatic op(input logic r, input logic fl, input logic t, input logic d, input logic [1:0] n);
      @(posedge clk);
      pc <= 24'($urandom);
      sp <= (24'($urandom) & 24'h7FFFFE) | 24'h000100;
      {done, return_from_exception, flg, trp, dir, tnum} <= {1'b1, r, fl, t, d, n};
      @(posedge clk);
      {done, return_from_exception, flg, trp, dir} <= 5'h00;
   endtask : op
   task automatic quiet;
      @(negedge clk);
      chk("busy", 24'h0, 24'(busy));
   endtask : quiet
   task automatic wait_pc;
      int n;
      n = npc;
      for (int i = 0; i < 200 && npc == n; i++) @(posedge clk);
      chk("pc_load", 24'h1, 24'(npc != n));
      @(posedge clk);
   endtask : wait_pc
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // Hang guard, far beyond the expected run length
   initial begin
      #3000000;
      err_count++;
      end_of_test();
   end
   initial begin
      {clk, nrst, wdt, wr, rd, rd_q, slow, done, return_from_exception, flg, trp, dir, ccr_wr, exr_wr} = '0;
      {ad, wd, cond_code_reg, extended_ctrl_reg, tnum, pc, sp} = '0;
      irq = '0;
      {err_count, compares, npc} = '0;
      void'($urandom(44));
      // Power-up reset, shortened: the design needs one edge, the system far more
      repeat (4) @(posedge clk);
      exp_pc.push_back(vpc(VEC_RESET));
      nrst <= 1'b1;
      wait_pc();
      irq.nmi <= 1'b1;
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      quiet();
      op(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
      quiet();
      exp_pc.push_back(vpc(VEC_NMI));
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      irq.nmi <= 1'b0;
      wait_pc();
      rreg(OFS_MODE, 8'h00);
      rreg(OFS_EXR, EXR_RST);
      rreg(OFS_MSTPA, MSTPA_RST);
      rreg(OFS_MSTPC, MSTPC_RST);
      wreg(OFS_CCR, 8'h00);
      rreg(OFS_CCR, CCR_RST);
      wreg(OFS_MODE, 8'h01);
      rreg(OFS_MODE, 8'h00);
      rreg(8'h10, 8'h00);
      $display("test reset done");
      // Traps 0..3 in mode 0 keep UI, mask and trace flag
      for (int n = 0; n < 4; n++) begin
         f = 8'($urandom) & 8'h7F;
         setf(f, 8'h80 | (f & 8'h07));
         exp_pc.push_back(vpc(VEC_TRAP0 + 7'(n)));
         op(1'b0, 1'b0, 1'b1, 1'b0, 2'(n));
         wait_pc();
         rreg(OFS_CCR, f | 8'h80);
         rreg(OFS_EXR, 8'h80 | (f & 8'h07));
      end
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      quiet();
      exp_pc.push_back(vpc(VEC_DIRECT));
      exp_pc.push_back(vpc(VEC_TRAP0 + 7'h03));
      op(1'b0, 1'b0, 1'b1, 1'b1, 2'h3);
      wait_pc();
      wait_pc();
      $display("test traps done");
      // Mode 2 with a slow partner: trace, return, priority, masking
      slow <= 1'b1;
      wreg(OFS_MODE, {6'h00, MODE_2});
      wreg(OFS_MODE, 8'h03);
      rreg(OFS_MODE, {6'h00, MODE_2});
      setf(8'h00, 8'h83);
      exp_pc.push_back(vpc(VEC_TRACE));
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      wait_pc();
      rreg(OFS_EXR, 8'h03);
      rreg(OFS_CCR, 8'h80);
      setf(8'h00, 8'h83);
      op(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
      quiet();
      exp_pc.push_back(vpc(VEC_TRACE));
      exp_pc.push_back(vpc(VEC_TRAP0 + 7'h01));
      op(1'b0, 1'b0, 1'b1, 1'b0, 2'h1);
      wait_pc();
      wait_pc();
      setf(8'h00, 8'h03);
      v = 7'h10 + 7'($urandom_range(111));
      irq <= '{nmi: 1'b0, irq: 1'b1, vec: v, lvl: 3'h5};
      exp_pc.push_back(vpc(v));
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      irq <= '0;
      wait_pc();
      rreg(OFS_EXR, 8'h05);
      irq <= '{nmi: 1'b0, irq: 1'b1, vec: v, lvl: 3'h2};
      op(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      irq <= '0;
      quiet();
      $display("test mode two done");
      // Watchdog overflow and a running pin reset
      exp_pc.push_back(vpc(VEC_RESET));
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      wait_pc();
      rreg(OFS_MODE, 8'h00);
      rreg(OFS_CCR, CCR_RST);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      chk("busy", 24'h1, 24'(busy));
      chk("req", 24'h0, 24'(mem.req));
      exp_pc.push_back(vpc(VEC_RESET));
      nrst <= 1'b1;
      wait_pc();
      rreg(OFS_MSTPB, MSTPB_RST);
      $display("test resets done");
      end_of_test();
   end
endmodule : testbench
bind ces_seq ces_chk chk_u (.CLK_I, .NRST_I, .WDT_OVF_I, .INSN_DONE_I, .INSN_RTE_I, .TRAP_I, .DIRECT_I,
   .IRQ_I, .PC_I, .SP_I, .MEM_O, .MEM_ACK_I, .PC_LOAD_O, .SP_LOAD_O, .SP_O, .BUSY_O, .INT_ACK_O, .CCR_O,
   .EXR_O, .MODE_O, .MSTPA_O, .MSTPB_O, .MSTPC_O);
`default_nettype wire
